// ===== rtl/dcc_dev.sv
/*
 device end of the dac command port: two-wire slave decoding channel writes,
 multi-word writes, power-down, clear code, software reset, readback and
 high-speed entry; asynchronous clear pin. assumes a 50 MHz clk much faster
 than the link, and pins that are asynchronous to it.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
// Function
// R1: clear pin loads clear code everywhere
// R2: default clear code gives zero-scale
// R3: clear on falling edge; exit after write
// R4: clear during write abandons that write
// R5: software reset zeroes clear code bits
// R6: clear code 11 ignores clear pin
// R7: software reset restores power-on codes, defaults
// R8: reset word bits select high-speed handling
// R9: device answers write and read addresses
// R10: write is address, command, high, low
// R11: channel updates at final acknowledge fall
// R12: repeated data pairs update same channel
// R13: access 1111 writes all channels
// R14: power-down command, mode and channel select
// R15: readback returns code, low nibble zero
// R16: high-speed master code is not acknowledged
// R17: power-down mode values per channel
// R18: synchronous mode updates at acknowledge fall
// R19: device never holds serial clock low
// R20: don't-care bits have no effect
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_dev
	import dcc_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// link
	dcc_if.dev                    dif,
	// device pins
	input  wire logic             clear_input_b,
	input  wire logic             load_strobe_input_b,
	input  wire logic             address_select_input,
	// analog side
	output logic [7:0][11:0]      dac_code,
	output logic [7:0][1:0]       pd_mode,
	output logic                  hs_mode,
	output logic                  cleared
);
	dcc_dev_t    r;
	dcc_dev_t    n;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic [15:0] word;
	logic [11:0] rb;
	logic [11:0] clr_val;
	logic [7:0]  aw;
	logic [7:0]  ar;

	function automatic logic chan_hit(input logic [3:0] acc, input int i);
		chan_hit = (acc == `DCC_ACC_ALL) || (acc == 4'(i));
	endfunction

	function automatic logic [11:0] clear_code_val(input logic [1:0] cc);
		case (cc)
			`DCC_CLR_MID:  clear_code_val = `DCC_CODE_MID;
			`DCC_CLR_FULL: clear_code_val = `DCC_CODE_FULL;
			default:       clear_code_val = `DCC_CODE_ZERO;
		endcase
	endfunction

	assign dac_code = r.dac;
	assign pd_mode  = r.pd;
	assign hs_mode  = r.hs;
	assign cleared  = r.cleared;
	assign dif.sda_o_d  = 1'b0;
	// only data is ever driven; the clock line has no driver here [R19]
	assign dif.sda_oe_d = r.sda_oe;

	always_comb begin
		n = r;
		n.scl_s1 = dif.scl;
		n.scl_s2 = r.scl_s1;
		n.scl_q  = r.scl_s2;
		n.sda_s1 = dif.sda;
		n.sda_s2 = r.sda_s1;
		n.sda_q  = r.sda_s2;
		n.clr_s1 = clear_input_b;
		n.clr_s2 = r.clr_s1;
		n.clr_q  = r.clr_s2;
		n.ld_s1  = load_strobe_input_b;
		n.ld_s2  = r.ld_s1;
		n.ld_q   = r.ld_s2;
		scl_rise  = r.scl_s2 & ~r.scl_q;
		scl_fall  = ~r.scl_s2 & r.scl_q;
		start_det = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
		stop_det  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
		word      = {r.msb, r.sh};
		rb        = r.inbuf[r.acc[2:0]];
		clr_val   = clear_code_val(r.clr_code); // [R2]
		aw        = address_select_input ? `DCC_ADDR_W1 : `DCC_ADDR_W0;
		ar        = address_select_input ? `DCC_ADDR_R1 : `DCC_ADDR_R0;

		if (start_det) begin
			// a repeated start also lands here and restarts byte counting
			n.st     = DCC_RX;
			n.bitcnt = 4'h0;
			n.idx    = 2'h0;
			n.sda_oe = 1'b0;
		end else if (stop_det) begin
			n.st     = DCC_IDLE;
			n.sda_oe = 1'b0;
			n.hs     = 1'b0;
		end else begin
			case (r.st)
				DCC_RX: begin
					if (scl_rise) begin
						n.sh     = {r.sh[6:0], r.sda_s2};
						n.bitcnt = r.bitcnt + 4'h1;
					end
					if (scl_fall && r.bitcnt == 4'h8) begin
						n.bitcnt = 4'h0;
						n.st     = DCC_ACK;
						n.sda_oe = 1'b1;
						case (r.idx)
							2'h0: begin
								if (r.sh == aw) begin // [R9]
									n.rw  = 1'b0;
									n.idx = 2'h1;
								end else if (r.sh == ar) begin // [R9]
									n.rw  = 1'b1;
								end else begin
									// foreign address or master code: stay off the bus [R16]
									n.st     = DCC_SKIP;
									n.sda_oe = 1'b0;
									if (r.sh[7:3] == `DCC_HS_PREFIX) begin
										n.hs = 1'b1;
									end
								end
							end
							2'h1: begin // [R10]
								n.cmd = r.sh[7:4];
								n.acc = r.sh[3:0];
								n.idx = 2'h2;
							end
							2'h2: begin
								n.msb = r.sh;
								n.idx = 2'h3;
							end
							default: begin
								// low byte in: zero marks a complete pair for its acknowledge
								n.idx = 2'h0;
							end
						endcase
					end
				end
				DCC_ACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'b0;
						n.st     = DCC_RX;
						if (r.rw) begin // [R15]
							n.st     = DCC_TX;
							n.sh     = rb[11:4];
							n.sda_oe = ~rb[11];
							n.idx    = 2'h0;
						end else if (r.idx == 2'h0) begin
							// back to high byte so further pairs reuse the command [R12]
							n.idx     = 2'h2;
							n.cleared = 1'b0; // [R3]
							case (r.cmd)
								`DCC_CMD_WR, `DCC_CMD_WR_UPD: begin
									for (int i = 0; i < 8; i++) begin
										if (chan_hit(r.acc, i)) begin // [R13]
											n.inbuf[i] = word[15:4]; // [R10] [R20]
											// with the load strobe low the output follows at once [R11] [R18]
											if (r.cmd == `DCC_CMD_WR_UPD || !r.ld_s2) begin
												n.dac[i] = word[15:4];
											end
										end
									end
								end
								`DCC_CMD_PD: begin
									for (int i = 0; i < 8; i++) begin
										if (word[`DCC_SEL_POS + i]) begin // [R14]
											n.pd[i] = word[`DCC_PD_POS +: 2]; // [R17]
										end
									end
								end
								`DCC_CMD_CLRCODE: begin
									n.clr_code = word[`DCC_CC_POS +: 2];
								end
								`DCC_CMD_SWRST: begin
									for (int i = 0; i < 8; i++) begin
										n.inbuf[i] = `DCC_POR_CODE; // [R7]
										n.dac[i]   = `DCC_POR_CODE; // [R7]
										n.pd[i]    = 2'h0;
									end
									n.clr_code = `DCC_CC_RST; // [R5]
									if (word[`DCC_SR_POS]) begin // [R8]
										n.hs = 1'b1;
									end else if (!word[`DCC_SR_POS + 1]) begin // [R8]
										n.hs = 1'b0;
									end
								end
								default: begin
									// unused command codes leave state alone [R20]
									n.cleared = r.cleared;
								end
							endcase
						end
					end
				end
				DCC_TX: begin
					if (scl_fall) begin
						if (r.bitcnt == 4'h7) begin
							n.sda_oe = 1'b0;
							n.st     = DCC_MACK;
							n.bitcnt = 4'h0;
						end else begin
							n.sh     = {r.sh[6:0], 1'b0};
							n.sda_oe = ~r.sh[6];
							n.bitcnt = r.bitcnt + 4'h1;
						end
					end
				end
				DCC_MACK: begin
					if (scl_rise) begin
						n.acked = ~r.sda_s2;
					end
					if (scl_fall) begin
						if (r.acked && r.idx == 2'h0) begin
							// low byte carries the last nibble, padded with zeros [R15]
							n.st     = DCC_TX;
							n.sh     = {rb[3:0], 4'h0};
							n.sda_oe = ~rb[3];
							n.idx    = 2'h1;
						end else begin
							n.st = DCC_SKIP;
						end
					end
				end
				default: begin
					n.st = r.st;
				end
			endcase
		end

		// falling edge of the load strobe moves buffers to outputs
		if (~r.ld_s2 & r.ld_q) begin
			n.dac = n.inbuf;
		end

		// clear has last word: it aborts any transfer in flight [R3] [R4]
		if (~r.clr_s2 & r.clr_q && r.clr_code != `DCC_CLR_IGNORE) begin // [R6]
			for (int i = 0; i < 8; i++) begin
				n.inbuf[i] = clr_val; // [R1]
				n.dac[i]   = clr_val; // [R1]
			end
			n.cleared = 1'b1;
			n.st      = DCC_SKIP; // [R4]
			n.sda_oe  = 1'b0;
			n.bitcnt  = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// power-on code is zero-scale, so an all-zero record is the reset state
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

// ===== common/dcc_defines.svh
/*
 constants for the dac clear/reset command port: bus addresses, command codes,
 field positions in the 16-bit data word, clear codes and host timing.
 assumes inclusion by bare name from design and testbench files.
*/
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH

// bus addresses with address_select_input low, and high
`define DCC_ADDR_W0        8'h90
`define DCC_ADDR_R0        8'h91
`define DCC_ADDR_W1        8'h92
`define DCC_ADDR_R1        8'h93
// high-speed master code is 0000 1xxx
`define DCC_HS_CODE        8'h08
`define DCC_HS_PREFIX      5'h01

// command nibbles
`define DCC_CMD_WR         4'h0
`define DCC_CMD_WR_UPD     4'h3
`define DCC_CMD_PD         4'h4
`define DCC_CMD_CLRCODE    4'h5
`define DCC_CMD_SWRST      4'h7
`define DCC_ACC_ALL        4'hf

// field positions in the word {high_data_byte, low_data_byte}
`define DCC_CC_POS         4
`define DCC_SEL_POS        5
`define DCC_PD_POS         13
`define DCC_SR_POS         14

// clear code settings and the codes they load
`define DCC_CLR_ZERO       2'h0
`define DCC_CLR_MID        2'h1
`define DCC_CLR_FULL       2'h2
`define DCC_CLR_IGNORE     2'h3
`define DCC_CODE_ZERO      12'h000
`define DCC_CODE_MID       12'h800
`define DCC_CODE_FULL      12'hfff
`define DCC_POR_CODE       12'h000
`define DCC_CC_RST         2'h0

// host register offsets
`define DCC_REG_CMD        2'h0
`define DCC_REG_DATA       2'h1
`define DCC_REG_GO         2'h2
`define DCC_REG_STAT       2'h3

// host serial clock timing
`define DCC_CLK_NS         20
`define DCC_SCL_PERIOD_NS  320
`define DCC_QTR_CLKS       ((`DCC_SCL_PERIOD_NS / `DCC_CLK_NS) / 4)

`endif

// ===== common/dcc_pkg.sv
/*
 types for the dac clear/reset command port: states, host operations and the
 state records of both ends. assumes dcc_defines.svh is on the include path.
*/
package dcc_pkg;
	typedef enum logic [2:0] {
		DCC_IDLE = 3'h0,
		DCC_RX   = 3'h1,
		DCC_ACK  = 3'h3,
		DCC_TX   = 3'h2,
		DCC_MACK = 3'h6,
		DCC_SKIP = 3'h4
	} dcc_dev_st_t;

	typedef enum logic [1:0] {
		DCC_OP_WRITE = 2'h0,
		DCC_OP_READ  = 2'h1,
		DCC_OP_HS    = 2'h3
	} dcc_op_t;

	typedef enum logic [2:0] {
		DCC_SYM_START = 3'h0,
		DCC_SYM_TX    = 3'h1,
		DCC_SYM_TXNA  = 3'h3,
		DCC_SYM_RXA   = 3'h2,
		DCC_SYM_RXN   = 3'h6,
		DCC_SYM_STOP  = 3'h7,
		DCC_SYM_END   = 3'h5
	} dcc_sym_t;

	typedef struct packed {
		logic              scl_s1, scl_s2, scl_q;
		logic              sda_s1, sda_s2, sda_q;
		logic              clr_s1, clr_s2, clr_q;
		logic              ld_s1, ld_s2, ld_q;
		dcc_dev_st_t       st;
		logic [3:0]        bitcnt;
		logic [7:0]        sh;
		logic [1:0]        idx;
		logic              rw;
		logic [3:0]        cmd;
		logic [3:0]        acc;
		logic [7:0]        msb;
		logic              acked;
		logic              sda_oe;
		logic              hs;
		logic              cleared;
		logic [1:0]        clr_code;
		logic [7:0][11:0]  inbuf;
		logic [7:0][11:0]  dac;
		logic [7:0][1:0]   pd;
	} dcc_dev_t;

	typedef struct packed {
		logic              sda_s1, sda_s2;
		logic [3:0]        div;
		logic [1:0]        q;
		logic [3:0]        bitn;
		logic [3:0]        step;
		dcc_op_t           op;
		logic              busy;
		logic              nack;
		logic              scl_oe;
		logic              sda_oe;
		logic [7:0]        sh;
		logic [15:0]       rx;
		logic [7:0]        cmdb;
		logic [15:0]       data;
		logic [31:0]       rdata;
	} dcc_host_t;
endpackage

// ===== common/dcc_if.sv
/*
 two-wire link between host and dac command port: open-drain clock and data.
 assumes each end drives its output enables; wire levels are resolved here.
*/
`timescale 1ns/1ps
interface dcc_if;
	logic scl_o_h;
	logic scl_oe_h;
	logic sda_o_h;
	logic sda_oe_h;
	logic sda_o_d;
	logic sda_oe_d;
	logic scl;
	logic sda;

	// pull-up wins unless an enabled driver pulls low
	assign scl = scl_oe_h ? scl_o_h : 1'b1;
	assign sda = (sda_oe_h ? sda_o_h : 1'b1) & (sda_oe_d ? sda_o_d : 1'b1);

	modport host (input scl, input sda, output scl_o_h, output scl_oe_h, output sda_o_h, output sda_oe_h);
	modport dev  (input scl, input sda, output sda_o_d, output sda_oe_d);
endinterface

// ===== rtl/dcc_host.sv
/*
 host end of the dac command port: two-wire master driving write, readback and
 high-speed-entry sequences, ordered through a small register port.
 assumes the device answers at its write/read address with address select low.
*/
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dcc_host
	import dcc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [1:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [31:0]      rdata,
	// link
	dcc_if.host              dif
);
	dcc_host_t r;
	dcc_host_t n;
	dcc_sym_t  sym;
	logic      tick;

	function automatic dcc_sym_t sym_at(input dcc_op_t op, input logic [3:0] s);
		sym_at = DCC_SYM_END;
		case (op)
			DCC_OP_READ: begin // [R15]
				case (s)
					4'h0, 4'h3: sym_at = DCC_SYM_START;
					4'h1, 4'h2, 4'h4: sym_at = DCC_SYM_TX;
					4'h5: sym_at = DCC_SYM_RXA;
					4'h6: sym_at = DCC_SYM_RXN;
					4'h7: sym_at = DCC_SYM_STOP;
					default: sym_at = DCC_SYM_END;
				endcase
			end
			DCC_OP_HS: begin // [R16]
				case (s)
					4'h0, 4'h2: sym_at = DCC_SYM_START;
					4'h1: sym_at = DCC_SYM_TXNA;
					4'h3, 4'h4, 4'h5, 4'h6: sym_at = DCC_SYM_TX;
					4'h7: sym_at = DCC_SYM_STOP;
					default: sym_at = DCC_SYM_END;
				endcase
			end
			default: begin // [R10]
				case (s)
					4'h0: sym_at = DCC_SYM_START;
					4'h1, 4'h2, 4'h3, 4'h4: sym_at = DCC_SYM_TX;
					4'h5: sym_at = DCC_SYM_STOP;
					default: sym_at = DCC_SYM_END;
				endcase
			end
		endcase
	endfunction

	function automatic logic [7:0] byte_at(input dcc_op_t op, input logic [3:0] s,
		input logic [7:0] cmdb, input logic [15:0] data);
		logic [2:0] k;
		k = 3'h0;
		case (op)
			DCC_OP_READ: k = (s == 4'h1) ? 3'h1 : (s == 4'h2) ? 3'h2 : (s == 4'h4) ? 3'h5 : 3'h0;
			DCC_OP_HS:   k = (s == 4'h1) ? 3'h6 : (s >= 4'h3 && s <= 4'h6) ? 3'(s - 4'h2) : 3'h0;
			default:     k = (s >= 4'h1 && s <= 4'h4) ? s[2:0] : 3'h0;
		endcase
		case (k)
			3'h1: byte_at = `DCC_ADDR_W0; // [R9]
			3'h2: byte_at = cmdb;
			3'h3: byte_at = data[15:8];
			3'h4: byte_at = data[7:0];
			3'h5: byte_at = `DCC_ADDR_R0; // [R9]
			3'h6: byte_at = `DCC_HS_CODE; // [R16]
			default: byte_at = 8'h00;
		endcase
	endfunction

	assign rdata        = r.rdata;
	assign dif.scl_o_h  = 1'b0;
	assign dif.sda_o_h  = 1'b0;
	assign dif.scl_oe_h = r.scl_oe;
	assign dif.sda_oe_h = r.sda_oe;

	always_comb begin
		n = r;
		n.sda_s1 = dif.sda;
		n.sda_s2 = r.sda_s1;
		n.rdata  = 32'h0;
		sym      = sym_at(r.op, r.step);
		tick     = r.busy && (r.div == 4'(`DCC_QTR_CLKS - 1));

		if (rd) begin
			case (addr)
				`DCC_REG_CMD:  n.rdata = {24'h0, r.cmdb};
				`DCC_REG_DATA: n.rdata = {16'h0, r.data};
				`DCC_REG_STAT: n.rdata = {14'h0, r.nack, r.busy, r.rx};
				default:       n.rdata = 32'h0;
			endcase
		end
		// orders arriving while busy are dropped
		if (wr && !r.busy) begin
			case (addr)
				`DCC_REG_CMD:  n.cmdb = wdata[7:0];
				`DCC_REG_DATA: n.data = wdata[15:0];
				`DCC_REG_GO: begin
					n.op   = dcc_op_t'(wdata[1:0] == 2'h2 ? 2'h0 : wdata[1:0]);
					n.busy = 1'b1;
					n.nack = 1'b0;
					n.step = 4'h0;
					n.bitn = 4'h0;
					n.q    = 2'h0;
					n.div  = 4'h0;
				end
				default: n.busy = r.busy;
			endcase
		end

		if (r.busy) begin
			n.div = tick ? 4'h0 : r.div + 4'h1;
		end
		if (tick) begin
			n.q = r.q + 2'h1;
			case (sym)
				DCC_SYM_START: begin
					case (r.q)
						2'h0: n.sda_oe = 1'b0;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b1;
						default: n.scl_oe = 1'b1;
					endcase
				end
				DCC_SYM_STOP: begin
					case (r.q)
						2'h0: n.sda_oe = 1'b1;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b0;
						default: n.scl_oe = 1'b0;
					endcase
				end
				DCC_SYM_END: begin
					n.busy = 1'b0;
					n.q    = 2'h0;
				end
				default: begin
					case (r.q)
						2'h0: begin
							if (sym == DCC_SYM_RXA || sym == DCC_SYM_RXN) begin
								n.sda_oe = (r.bitn == 4'h8) && (sym == DCC_SYM_RXA); // [R15]
							end else begin
								n.sda_oe = (r.bitn == 4'h8) ? 1'b0 : ~r.sh[7];
							end
						end
						2'h1: n.scl_oe = 1'b0;
						2'h2: begin
							if (r.bitn == 4'h8) begin
								if (sym == DCC_SYM_TX && r.sda_s2) begin
									n.nack = 1'b1;
								end
							end else if (sym == DCC_SYM_RXA || sym == DCC_SYM_RXN) begin
								n.sh = {r.sh[6:0], r.sda_s2};
							end
						end
						default: begin
							n.scl_oe = 1'b1;
							n.bitn   = r.bitn + 4'h1;
							if (sym == DCC_SYM_TX || sym == DCC_SYM_TXNA) begin
								n.sh = {r.sh[6:0], 1'b0};
							end
							if (r.bitn == 4'h8 && (sym == DCC_SYM_RXA || sym == DCC_SYM_RXN)) begin
								n.rx = {r.rx[7:0], r.sh};
							end
						end
					endcase
				end
			endcase
			// each symbol ends on its last quarter; the next byte is preloaded then
			if (r.q == 2'h3 && (r.bitn == 4'h8 || sym == DCC_SYM_START || sym == DCC_SYM_STOP)) begin
				n.step = r.step + 4'h1;
				n.bitn = 4'h0;
				n.sh   = byte_at(r.op, r.step + 4'h1, r.cmdb, r.data);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

// ===== test/dcc_sva.sv
/*
 checker for the two-wire link between host and dac command port.
 assumes the resolved wires and every driver enable of the link are wired in by name.
*/
`timescale 1ns/1ps
module dcc_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// host drivers
	input wire logic scl_o_h,
	input wire logic scl_oe_h,
	input wire logic sda_o_h,
	input wire logic sda_oe_h,
	// device drivers
	input wire logic sda_o_d,
	input wire logic sda_oe_d,
	// resolved wires
	input wire logic scl,
	input wire logic sda
);
	typedef struct packed {
		logic       scl_p;
		logic       sda_p;
		logic       first;
		logic [3:0] cnt;
		logic [7:0] sh;
	} dcc_mon_t;

	dcc_mon_t mon_r;
	dcc_mon_t mon_nxt;
	logic     start;
	logic     scl_rise;
	logic     ninth;

	assign start    = scl & mon_r.scl_p & mon_r.sda_p & ~sda;
	assign scl_rise = scl & ~mon_r.scl_p;
	// ack slot of the first byte after a start or repeated start
	assign ninth    = scl_rise & (mon_r.cnt == 4'h8) & mon_r.first;

	always_comb begin
		mon_nxt = mon_r;
		mon_nxt.scl_p = scl;
		mon_nxt.sda_p = sda;
		if (start) begin
			mon_nxt.cnt = 4'h0;
			mon_nxt.first = 1'b1;
		end else if (scl_rise && mon_r.cnt == 4'h8) begin
			mon_nxt.cnt = 4'h0;
			mon_nxt.first = 1'b0;
		end else if (scl_rise) begin
			mon_nxt.sh = {mon_r.sh[6:0], sda};
			mon_nxt.cnt = mon_r.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			mon_r <= '0;
		else
			mon_r <= mon_nxt;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	ack_write_a: assert property (ninth && mon_r.sh == 8'h90 |-> !sda)
		else $error("write address not acknowledged");
	ack_read_a: assert property (ninth && mon_r.sh == 8'h91 |-> !sda)
		else $error("read address not acknowledged");
	hs_noack_a: assert property (ninth && mon_r.sh[7:3] == 5'h01 |-> sda)
		else $error("high-speed master code acknowledged");
	no_stretch_a: assert property (!scl |-> scl_oe_h && !scl_o_h)
		else $error("serial clock low without host pulling it");
	drive_low_a: assert property ($rose(sda_oe_d) |-> !scl)
		else $error("device took data line while clock high");
	drive_hold_a: assert property ($rose(sda_oe_d) |=> sda_oe_d[*8] ##[1:200] !sda_oe_d)
		else $error("device data drive too short or never released");
	open_drain_a: assert property (!(scl_oe_h && scl_o_h) && !(sda_oe_h && sda_o_h) && !(sda_oe_d && sda_o_d))
		else $error("driver enabled with a high value");
	scl_high_a: assert property ($rose(scl) |-> scl[*8])
		else $error("serial clock high phase too short");
endmodule

// ===== test/dac_clear_reset_command_port_tb.sv
/*
 testbench for host and dac command port joined over the link, with a queue-free
 behavioural model of channel codes, power-down modes and clear state.
 assumes load strobe and address select tied low (synchronous mode, address 0x90).
*/
`timescale 1ns/1ps
`include "dcc_defines.svh"
module dac_clear_reset_command_port_tb
	import dcc_pkg::*;
;
	logic            clk;
	logic            rst_b;
	logic [1:0]      addr;
	logic [31:0]     wdata;
	logic            wr;
	logic            rd;
	logic [31:0]     rdata;
	logic            clear_input_b;
	logic            load_strobe_input_b;
	logic            address_select_input;
	logic [7:0][11:0] dac_code;
	logic [7:0][1:0] pd_mode;
	logic            hs_mode;
	logic            cleared;
	int              err_total;
	int              total_checks;
	logic [11:0]     mcode [8];
	logic [1:0]      mpd [8];
	logic [1:0]      mcc;
	logic            mclr;
	logic [31:0]     stat;
	logic [11:0]     v;
	logic [7:0]      sel;
	int              ch;
	int              hs_cnt = 0;
	int              hs_base;

	dcc_if link();
	dcc_host u_dcc_host (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.dif(link));
	dcc_dev u_dcc_dev (.clk(clk), .rst_b(rst_b), .dif(link), .clear_input_b(clear_input_b),
		.load_strobe_input_b(load_strobe_input_b), .address_select_input(address_select_input),
		.dac_code(dac_code), .pd_mode(pd_mode), .hs_mode(hs_mode), .cleared(cleared));
	dcc_sva chk_link (.clk(clk), .rst_b(rst_b), .scl_o_h(link.scl_o_h), .scl_oe_h(link.scl_oe_h),
		.sda_o_h(link.sda_o_h), .sda_oe_h(link.sda_oe_h), .sda_o_d(link.sda_o_d), .sda_oe_d(link.sda_oe_d),
		.scl(link.scl), .sda(link.sda));

	always #10 clk = ~clk;

	// high-speed state only lasts until the stop, so count the cycles it is seen
	always @(posedge clk) begin
		if (hs_mode === 1'b1) begin
			hs_cnt <= hs_cnt + 1;
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic xfer(input logic [1:0] op, input logic [7:0] c, input logic [15:0] d);
		int n;
		reg_wr(`DCC_REG_CMD, {24'h0, c});
		reg_wr(`DCC_REG_DATA, {16'h0, d});
		reg_wr(`DCC_REG_GO, {30'h0, op});
		n = 0;
		stat = 32'h1_0000;
		while (stat[16] !== 1'b0 && n < 2000) begin
			reg_rd(`DCC_REG_STAT, stat);
			n++;
		end
		if (n == 2000) begin
			err_total++;
			$display("CHECK FAILED busy expected 0 seen 1");
		end
	endtask

	task automatic set_all(input logic [11:0] c);
		foreach (mcode[i]) mcode[i] = c;
	endtask

	task automatic cmp_all();
		for (int i = 0; i < 8; i++) begin
			chk("dac_code", {20'h0, dac_code[i]}, {20'h0, mcode[i]});
			chk("pd_mode", {30'h0, pd_mode[i]}, {30'h0, mpd[i]});
		end
		chk("cleared", {31'h0, cleared}, {31'h0, mclr});
	endtask

	task automatic clr_pulse();
		@(posedge clk);
		clear_input_b <= 1'b0;
		repeat (8) @(posedge clk);
		clear_input_b <= 1'b1;
		repeat (8) @(posedge clk);
		if (mcc != `DCC_CLR_IGNORE) begin
			set_all(mcc == `DCC_CLR_ZERO ? `DCC_CODE_ZERO : mcc == `DCC_CLR_MID ? `DCC_CODE_MID : `DCC_CODE_FULL);
			mclr = 1'b1;
		end
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		addr = 2'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		clear_input_b = 1'b1;
		load_strobe_input_b = 1'b0;
		address_select_input = 1'b0;
		err_total = 0;
		total_checks = 0;
		mcc = `DCC_CC_RST;
		mclr = 1'b0;
		set_all(`DCC_POR_CODE);
		foreach (mpd[i]) mpd[i] = 2'h0;
		void'($urandom(32'h5d897bfa));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		cmp_all();
		for (int k = 0; k < 8; k++) begin
			v = 12'($urandom);
			xfer(DCC_OP_WRITE, {`DCC_CMD_WR, 4'(k)}, {v, 4'($urandom)});
			mcode[k] = v;
			cmp_all();
		end
		$display("test single writes done");
		// broadcast after the high-speed master code
		v = 12'($urandom);
		hs_base = hs_cnt;
		xfer(DCC_OP_HS, {`DCC_CMD_WR_UPD, `DCC_ACC_ALL}, {v, 4'($urandom)});
		set_all(v);
		cmp_all();
		chk("hs_mode", {31'h0, hs_cnt != hs_base}, 32'h1);
		$display("test broadcast done");
		for (int m = 0; m < 4; m++) begin
			sel = 8'($urandom);
			xfer(DCC_OP_WRITE, {`DCC_CMD_PD, 4'($urandom)}, {1'($urandom), 2'(m), sel, 5'($urandom)});
			for (int i = 0; i < 8; i++) if (sel[i]) mpd[i] = 2'(m);
			cmp_all();
		end
		$display("test power-down done");
		for (int k = 0; k < 3; k++) begin
			ch = $urandom_range(7);
			xfer(DCC_OP_READ, {`DCC_CMD_WR, 4'(ch)}, 16'h0);
			chk("readback", {16'h0, stat[15:0]}, {16'h0, mcode[ch], 4'h0});
		end
		$display("test readback done");
		for (int c = 0; c < 4; c++) begin
			xfer(DCC_OP_WRITE, {`DCC_CMD_CLRCODE, 4'($urandom)}, {10'($urandom), 2'(c), 4'($urandom)});
			mcc = 2'(c);
			mclr = 1'b0;
			clr_pulse();
			cmp_all();
		end
		$display("test clear codes done");
		// mid scale differs from the full codes left above, so an unabandoned write shows
		xfer(DCC_OP_WRITE, {`DCC_CMD_CLRCODE, 4'h0}, {10'h0, `DCC_CLR_MID, 4'h0});
		mcc = `DCC_CLR_MID;
		fork
			xfer(DCC_OP_WRITE, {`DCC_CMD_WR, 4'h2}, {12'h5a5, 4'h0});
			begin
				repeat (210) @(posedge clk);
				clr_pulse();
			end
		join
		cmp_all();
		$display("test clear in mid-write done");
		for (int m = 0; m < 4; m++) begin
			xfer(DCC_OP_WRITE, {`DCC_CMD_CLRCODE, 4'h0}, {10'h0, `DCC_CLR_MID, 4'h0});
			xfer(DCC_OP_WRITE, {`DCC_CMD_PD, 4'h0}, {1'b0, 2'h3, 8'hff, 5'h0});
			mcc = `DCC_CLR_MID;
			mclr = 1'b0;
			foreach (mpd[i]) mpd[i] = 2'h3;
			cmp_all();
			hs_base = hs_cnt;
			xfer(DCC_OP_WRITE, {`DCC_CMD_SWRST, 4'($urandom)}, {2'(m), 14'($urandom)});
			mcc = `DCC_CC_RST;
			set_all(`DCC_POR_CODE);
			foreach (mpd[i]) mpd[i] = 2'h0;
			cmp_all();
			chk("hs_mode", {31'h0, hs_cnt != hs_base}, {31'h0, m[0]});
			clr_pulse();
			cmp_all();
		end
		$display("test software reset done");
		reg_rd(`DCC_REG_GO, stat);
		chk("go_read", stat, 32'h0);
		wrap_up();
	end

	// the whole sequence needs about 22000 cycles
	initial begin
		repeat (80000) @(posedge clk);
		err_total++;
		$display("CHECK FAILED watchdog expected done seen hang");
		wrap_up();
	end
endmodule
